//--- inc/pin_timer_pkg.sv
// What this block does
// - Output pin serves as busy indicator or as message-controlled output.
// - New pin settings take effect when the message is received.
// - Locked pin ignores changes unless the same message unlocks first.
// - Lock on exit is applied after all other pin actions.
// - A message can set the pin on, off, or toggle it.
// - Pin electrical level follows the configured polarity.
// - Expired timeout drives the pin off.
// - Halting the timeout freezes its remaining value.
// - Starting the timeout leaves the pin state unchanged.
// - Default source loads stored default timeout, then runs.
// - Message source loads the carried timeout, then runs.
// - Resume continues from held value; expired value reverts to halted.
// - No-change fields leave present settings unmodified.
// - Sixteen elapsed timers, indexed 00 to 15.
// - Timers reachable by message and by a timer access command.
// - All timers update continuously per own configuration.
// - Displayed running timer value refreshes as it changes.
// - Each timer can be run or halted by command.
// - Direction changes without stopping or resetting the count.
// - Each timer accepts a preset within the legal range.
// - Wrap past maximum or below zero sets the overflow flag.
// - A message can clear a timer overflow flag.
package pin_timer_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_CMD = 8'h00;
    localparam logic [7:0] ADDR_PIN_STAT = 8'h04;
    localparam logic [7:0] ADDR_PIN_DEF = 8'h08;
    localparam logic [7:0] ADDR_TMR_SEL = 8'h0C;
    localparam logic [7:0] ADDR_TMR_CMD = 8'h10;
    localparam logic [7:0] ADDR_TMR_HRS = 8'h14;
    localparam logic [7:0] ADDR_TMR_SUB = 8'h18;
    localparam logic [7:0] ADDR_TMR_STAT = 8'h1C;
    localparam logic [7:0] ADDR_TMR_ACC = 8'h20;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_10MS_NS = 10_000_000;
    localparam int TICK_CYC = TICK_10MS_NS / (1_000_000_000 / CLK_HZ);
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
    localparam logic [6:0] HUND_PER_S = 7'h64;
    localparam logic [6:0] SEC_PER_MIN = 7'h3C;
    localparam logic [13:0] HOUR_MAX = 14'h270F;
    localparam logic [6:0] SUB_MAX = 7'h63;
    localparam logic [5:0] MIN_SEC_MAX = 6'h3B;
    // Timeout units: 10 ms ticks, per second, per minute.
    localparam logic [1:0] TO_UNIT_10MS = 2'h0;
    localparam logic [1:0] TO_UNIT_S = 2'h1;
    localparam logic [1:0] TO_UNIT_MIN = 2'h2;
    localparam logic [12:0] TICKS_PER_S = 13'h0064;
    localparam logic [12:0] TICKS_PER_MIN = 13'h1770;
    localparam logic [18:0] TO_RESET = 19'h00064;
    localparam int N_TMR = 16;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NC = 2'b00,
        ACT_ON = 2'b01,
        ACT_OFF = 2'b10,
        ACT_TOG = 2'b11
    } pin_act_t;
    typedef enum logic [1:0] {
        TOA_NC = 2'b00,
        TOA_HALT = 2'b01,
        TOA_RUN = 2'b10
    } to_act_t;
    typedef enum logic [1:0] {
        SRC_DEFAULT = 2'b00,
        SRC_MESSAGE = 2'b01,
        SRC_RESUME = 2'b10
    } to_src_t;
    // Pin command word bit layout, written at ADDR_PIN_CMD.
    typedef struct packed {
        logic [9:0] unused;
        logic [1:0] to_unit;
        logic [6:0] to_value;
        to_src_t to_src;
        to_act_t to_act;
        pin_act_t status;
        logic [1:0] polarity;
        logic [1:0] mode;
        logic lock_exit;
        logic unlock_entry;
    } pin_cmd_t;
    // Timer command: bit0 run/halt change, bit1 run, bit2 dir change, bit3 down,
    // bit4 load preset, bit5 clear overflow.
    typedef struct packed {
        logic [25:0] unused;
        logic clr_ovf;
        logic load;
        logic down;
        logic dir_chg;
        logic run;
        logic run_chg;
    } tmr_cmd_t;
    typedef struct packed {
        logic [13:0] hours;
        logic [5:0] mins;
        logic [5:0] secs;
        logic [6:0] hund;
    } tval_t;
endpackage

//--- rtl/elapsed_timer.sv
`timescale 1ns/1ps
`default_nettype none
module elapsed_timer
    import pin_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_tick,
    // Command
    input wire logic i_cmd_we,
    input wire tmr_cmd_t i_cmd,
    input wire tval_t i_preset,
    // State
    output tval_t o_value,
    output logic o_running,
    output logic o_down,
    output logic o_ovf
);
    typedef struct packed {
        tval_t v;
        logic run;
        logic down;
        logic ovf;
    } st_t;
    st_t st_r;
    st_t st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (i_tick && st_r.run) begin
            if (!st_r.down) begin
                if (st_r.v.hund != SUB_MAX) begin
                    st_nxt.v.hund = st_r.v.hund + 7'h01;
                end else begin
                    st_nxt.v.hund = 7'h00;
                    if (st_r.v.secs != MIN_SEC_MAX) begin
                        st_nxt.v.secs = st_r.v.secs + 6'h01;
                    end else begin
                        st_nxt.v.secs = 6'h00;
                        if (st_r.v.mins != MIN_SEC_MAX) begin
                            st_nxt.v.mins = st_r.v.mins + 6'h01;
                        end else begin
                            st_nxt.v.mins = 6'h00;
                            if (st_r.v.hours != HOUR_MAX) begin
                                st_nxt.v.hours = st_r.v.hours + 14'h0001;
                            end else begin
                                st_nxt.v.hours = 14'h0000;
                                st_nxt.ovf = 1'b1;
                            end
                        end
                    end
                end
            end else begin
                if (st_r.v.hund != 7'h00) begin
                    st_nxt.v.hund = st_r.v.hund - 7'h01;
                end else begin
                    st_nxt.v.hund = SUB_MAX;
                    if (st_r.v.secs != 6'h00) begin
                        st_nxt.v.secs = st_r.v.secs - 6'h01;
                    end else begin
                        st_nxt.v.secs = MIN_SEC_MAX;
                        if (st_r.v.mins != 6'h00) begin
                            st_nxt.v.mins = st_r.v.mins - 6'h01;
                        end else begin
                            st_nxt.v.mins = MIN_SEC_MAX;
                            if (st_r.v.hours != 14'h0000) begin
                                st_nxt.v.hours = st_r.v.hours - 14'h0001;
                            end else begin
                                st_nxt.v.hours = HOUR_MAX;
                                st_nxt.ovf = 1'b1;
                            end
                        end
                    end
                end
            end
        end
        if (i_cmd_we) begin
            if (i_cmd.run_chg) begin
                st_nxt.run = i_cmd.run;
            end
            if (i_cmd.dir_chg) begin
                st_nxt.down = i_cmd.down;
            end
            if (i_cmd.load) begin
                st_nxt.v = i_preset;
            end
            // A wrap in the same cycle as the clear keeps the flag set if it was clear before.
            if (i_cmd.clr_ovf && !(st_nxt.ovf && !st_r.ovf)) begin
                st_nxt.ovf = 1'b0;
            end
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign o_value = st_r.v;
    assign o_running = st_r.run;
    assign o_down = st_r.down;
    assign o_ovf = st_r.ovf;
endmodule // elapsed_timer
`default_nettype wire

//--- rtl/pin_timer_top.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pin_timer_top
    import pin_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Busy source from the message engine
    input wire logic i_busy,
    // Open-collector output pin
    output logic o_pin_out,
    output logic o_pin_oe_n
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [16:0] tick_cnt;
        logic tick;
        logic mode_out;
        logic pol_low;
        logic locked;
        logic pin_on;
        logic to_run;
        logic [18:0] to_cnt;
        logic [18:0] to_def;
        logic [3:0] sel;
        tval_t preset;
        logic [31:0] rdata;
        logic pin_lvl;
    } st_t;
    st_t st_r;
    st_t st_nxt;
    logic apb_wr;
    logic apb_rd;
    logic tmr_we;
    tmr_cmd_t tmr_cmd;
    logic [3:0] tmr_idx;
    tval_t tmr_val [N_TMR];
    logic [N_TMR-1:0] tmr_run;
    logic [N_TMR-1:0] tmr_down;
    logic [N_TMR-1:0] tmr_ovf;
    pin_cmd_t pcmd;
    // Converts a message timeout into 10 ms ticks.
    function automatic logic [18:0] to_ticks(input logic [1:0] unit, input logic [6:0] val);
        logic [18:0] r;
        r = 19'h00000;
        if (unit == TO_UNIT_10MS) begin
            r = {12'h000, val};
        end else if (unit == TO_UNIT_S) begin
            r = 19'({val, 12'h000} / 19'h01000) * 19'(TICKS_PER_S);
        end else if (unit == TO_UNIT_MIN) begin
            r = 19'(val) * 19'(TICKS_PER_MIN);
        end
        return r;
    endfunction
    assign apb_wr = i_psel && i_penable && i_pwrite;
    // Read data is captured in the setup cycle so that it stands at the access edge.
    assign apb_rd = i_psel && !i_penable && !i_pwrite;
    assign pcmd = pin_cmd_t'(i_pwdata);
    // ---------------------------------------------------------------
    // Elapsed timers
    // ---------------------------------------------------------------
    // Timer commands arrive either directly or through the access command word.
    always_comb begin
        tmr_we = 1'b0;
        tmr_idx = st_r.sel;
        tmr_cmd = tmr_cmd_t'(i_pwdata);
        if (apb_wr && i_paddr == ADDR_TMR_CMD) begin
            tmr_we = 1'b1;
        end else if (apb_wr && i_paddr == ADDR_TMR_ACC) begin
            tmr_we = 1'b1;
            tmr_idx = i_pwdata[11:8];
            tmr_cmd = tmr_cmd_t'({26'h0, i_pwdata[5:0]});
        end
    end
    generate
        for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
            elapsed_timer u_tmr (
                .i_ref_clk(i_ref_clk),
                .i_reset_n(i_reset_n),
                .i_tick(st_r.tick),
                .i_cmd_we(tmr_we && tmr_idx == 4'(g)),
                .i_cmd(tmr_cmd),
                .i_preset(st_r.preset),
                .o_value(tmr_val[g]),
                .o_running(tmr_run[g]),
                .o_down(tmr_down[g]),
                .o_ovf(tmr_ovf[g])
            );
        end
    endgenerate
    // ---------------------------------------------------------------
    // Pin control and bus
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = 17'h00000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 17'h00001;
        end
        if (st_r.tick && st_r.to_run) begin
            if (st_r.to_cnt <= 19'h00001) begin
                st_nxt.to_cnt = 19'h00000;
                st_nxt.to_run = 1'b0;
                st_nxt.pin_on = 1'b0;
            end else begin
                st_nxt.to_cnt = st_r.to_cnt - 19'h00001;
            end
        end
        if (apb_wr) begin
            if (i_paddr == ADDR_PIN_CMD) begin
                if (!st_r.locked || pcmd.unlock_entry) begin
                    st_nxt.locked = 1'b0;
                    if (pcmd.mode[1]) begin
                        st_nxt.mode_out = pcmd.mode[0];
                    end
                    if (pcmd.polarity[1]) begin
                        st_nxt.pol_low = pcmd.polarity[0];
                    end
                    if (pcmd.status == ACT_ON) begin
                        st_nxt.pin_on = 1'b1;
                    end else if (pcmd.status == ACT_OFF) begin
                        st_nxt.pin_on = 1'b0;
                    end else if (pcmd.status == ACT_TOG) begin
                        st_nxt.pin_on = !st_r.pin_on;
                    end
                    if (pcmd.to_act == TOA_HALT) begin
                        st_nxt.to_run = 1'b0;
                        st_nxt.to_cnt = st_r.to_cnt;
                    end else if (pcmd.to_act == TOA_RUN) begin
                        if (pcmd.to_src == SRC_DEFAULT) begin
                            st_nxt.to_cnt = st_r.to_def;
                            st_nxt.to_run = 1'b1;
                        end else if (pcmd.to_src == SRC_MESSAGE) begin
                            st_nxt.to_cnt = to_ticks(pcmd.to_unit, pcmd.to_value);
                            st_nxt.to_run = 1'b1;
                        end else begin
                            st_nxt.to_run = (st_r.to_cnt != 19'h00000);
                        end
                    end
                    if (pcmd.lock_exit) begin
                        st_nxt.locked = 1'b1;
                    end
                end
            end else if (i_paddr == ADDR_PIN_DEF) begin
                st_nxt.to_def = i_pwdata[18:0];
            end else if (i_paddr == ADDR_TMR_SEL) begin
                st_nxt.sel = i_pwdata[3:0];
            end else if (i_paddr == ADDR_TMR_HRS) begin
                st_nxt.preset.hours = i_pwdata[13:0];
            end else if (i_paddr == ADDR_TMR_SUB) begin
                st_nxt.preset.mins = i_pwdata[21:16];
                st_nxt.preset.secs = i_pwdata[13:8];
                st_nxt.preset.hund = i_pwdata[6:0];
            end
        end
        st_nxt.rdata = 32'h00000000;
        if (apb_rd) begin
            if (i_paddr == ADDR_PIN_STAT) begin
                st_nxt.rdata = {st_r.to_cnt, 8'h00, st_r.to_run, st_r.pin_on,
                    st_r.locked, st_r.pol_low, st_r.mode_out};
            end else if (i_paddr == ADDR_PIN_DEF) begin
                st_nxt.rdata = {13'h0000, st_r.to_def};
            end else if (i_paddr == ADDR_TMR_SEL) begin
                st_nxt.rdata = {28'h0000000, st_r.sel};
            end else if (i_paddr == ADDR_TMR_HRS) begin
                st_nxt.rdata = {18'h00000, tmr_val[st_r.sel].hours};
            end else if (i_paddr == ADDR_TMR_SUB) begin
                st_nxt.rdata = {10'h000, tmr_val[st_r.sel].mins, 2'h0,
                    tmr_val[st_r.sel].secs, 1'b0, tmr_val[st_r.sel].hund};
            end else if (i_paddr == ADDR_TMR_STAT) begin
                st_nxt.rdata = {29'h00000000, tmr_ovf[st_r.sel], tmr_down[st_r.sel],
                    tmr_run[st_r.sel]};
            end
        end
        // Busy mode drives the pin from the engine, output mode from the state.
        st_nxt.pin_lvl = (st_nxt.mode_out ? st_nxt.pin_on : i_busy) ^ st_nxt.pol_low;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            st_r <= '0;
            st_r.to_def <= TO_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Open collector: the transistor pulls low while enabled, else floats.
    assign o_pin_out = 1'b0;
    assign o_pin_oe_n = !st_r.pin_lvl;
    assign o_pready = i_psel && i_penable;
    assign o_prdata = st_r.rdata;
    assign o_pslverr = 1'b0;
endmodule // pin_timer_top
`default_nettype wire

//--- bench/pin_timer_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pin_timer_checker
    import pin_timer_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Pin
    input wire logic i_busy,
    input wire logic o_pin_out,
    input wire logic o_pin_oe_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_acc;
        i_psel && i_penable;
    endsequence
    sequence s_wr_pin;
        i_psel && i_penable && i_pwrite && i_paddr == ADDR_PIN_CMD;
    endsequence
    property p_ready;
        s_acc |-> o_pready;
    endproperty
    property p_ready_idle;
        !(i_psel && i_penable) |-> !o_pready;
    endproperty
    property p_slverr;
        o_pslverr == 1'b0;
    endproperty
    property p_pin_out;
        o_pin_out == 1'b0;
    endproperty
    property p_rd_clear;
        !(i_psel && !i_penable && !i_pwrite) |=> o_prdata == 32'h0;
    endproperty
    property p_nc_hold;
        s_wr_pin ##0 (i_pwdata[9:2] == 8'h00 && $stable(i_busy)) |=> $stable(o_pin_oe_n);
    endproperty
    property p_reset_off;
        disable iff (1'b0) !i_reset_n |=> o_pin_oe_n;
    endproperty
    property p_unmapped;
        (i_psel && !i_penable && !i_pwrite && i_paddr > ADDR_TMR_ACC) |=> o_prdata == 32'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing in access");
    a_ready_idle: assert property (p_ready_idle) else $error("pready outside access");
    a_slverr: assert property (p_slverr) else $error("pslverr raised");
    a_pin_out: assert property (p_pin_out) else $error("pin data not low");
    a_rd_clear: assert property (p_rd_clear) else $error("read data not cleared");
    a_nc_hold: assert property (p_nc_hold) else $error("pin moved on no-change");
    a_reset_off: assert property (p_reset_off) else $error("pin not off in reset");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // pin_timer_checker
`default_nettype wire

//--- bench/apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    // Clock and answers
    input wire logic i_ref_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    // Pin seen through the pull-up
    input wire logic i_pin_out,
    input wire logic i_pin_oe_n,
    output logic o_pin_level,
    // Requests
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    // The pull-up lifts the line whenever the collector is released.
    assign o_pin_level = i_pin_oe_n ? 1'b1 : i_pin_out;
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        o_psel <= 1'b1;
        o_pwrite <= wr;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_ref_clk);
        o_penable <= 1'b1;
        @(posedge i_ref_clk);
        while (i_pready !== 1'b1 && n < 16) begin
            @(posedge i_ref_clk);
            n++;
        end
        ok = (i_pready === 1'b1);
        // Read data stands at the access edge, so it is taken at that edge.
        q = i_prdata;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule // apb_host
`default_nettype wire

//--- bench/pin_timer_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pin_timer_top_tb;
    import pin_timer_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic busy = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pin_out, oe_n, lvl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0;
    int n_tests = 0;
    always #50 clk = ~clk;
    pin_timer_top dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_busy(busy), .o_pin_out(pin_out),
        .o_pin_oe_n(oe_n));
    apb_host u_host (.i_ref_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pin_out(pin_out),
        .i_pin_oe_n(oe_n), .o_pin_level(lvl), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic ok;
        u_host.xfer(1'b1, a, d, r, ok);
        chk({31'h0, ok}, 32'h1);
        // Let the registered pin level settle before any comparison.
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ok;
        u_host.xfer(1'b0, a, 32'h0, q, ok);
        chk({31'h0, ok}, 32'h1);
    endtask
    function automatic logic [31:0] pc(input logic [1:0] md, input logic [1:0] pl,
        input pin_act_t st, input to_act_t ta, input to_src_t sr, input logic [6:0] v,
        input logic ul, input logic le);
        pin_cmd_t c;
        c = '0;
        c.mode = md;
        c.polarity = pl;
        c.status = st;
        c.to_act = ta;
        c.to_src = sr;
        c.to_value = v;
        c.unlock_entry = ul;
        c.lock_exit = le;
        return c;
    endfunction
    task automatic t_reset;
        chk(lvl, 1);
        rd(ADDR_PIN_DEF);
        chk(q, 32'd100);
        rd(ADDR_PIN_STAT);
        chk(q[4:0], 5'h00);
        $display("test reset done");
    endtask
    task automatic t_pin;
        pin_act_t acts [4] = '{ACT_ON, ACT_OFF, ACT_TOG, ACT_TOG};
        logic ons [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(ADDR_PIN_CMD, pc(2'b11, 2'b10, ACT_NC, TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, acts[i], TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
            chk(lvl, !ons[i]);
            rd(ADDR_PIN_STAT);
            chk(q[3], ons[i]);
        end
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b11, ACT_ON, TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
        chk(lvl, 1);
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b10, ACT_NC, TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
        chk(lvl, 0);
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_OFF, TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
        $display("test pin done");
    endtask
    task automatic t_lock;
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_ON, TOA_NC, SRC_DEFAULT, 7'h0, 0, 1));
        rd(ADDR_PIN_STAT);
        chk(q[3:2], 2'b11);
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_OFF, TOA_NC, SRC_DEFAULT, 7'h0, 0, 0));
        chk(lvl, 0);
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_OFF, TOA_NC, SRC_DEFAULT, 7'h0, 1, 0));
        chk(lvl, 1);
        rd(ADDR_PIN_STAT);
        chk(q[3:2], 2'b00);
        $display("test lock done");
    endtask
    task automatic t_tout;
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_RUN, SRC_MESSAGE, 7'h05, 0, 0));
        chk(lvl, 1);
        rd(ADDR_PIN_STAT);
        chk({q[31:13], q[4]}, {19'd5, 1'b1});
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_HALT, SRC_DEFAULT, 7'h0, 0, 0));
        rd(ADDR_PIN_STAT);
        chk({q[31:13], q[4]}, {19'd5, 1'b0});
        wr(ADDR_PIN_DEF, 32'd40);
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_RUN, SRC_DEFAULT, 7'h0, 0, 0));
        rd(ADDR_PIN_STAT);
        chk({q[31:13], q[4]}, {19'd40, 1'b1});
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_HALT, SRC_DEFAULT, 7'h0, 0, 0));
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_RUN, SRC_RESUME, 7'h0, 0, 0));
        rd(ADDR_PIN_STAT);
        chk({q[31:13], q[4]}, {19'd40, 1'b1});
        wr(ADDR_PIN_CMD, pc(2'b00, 2'b00, ACT_NC, TOA_HALT, SRC_DEFAULT, 7'h0, 0, 0));
        $display("test timeout done");
    endtask
    task automatic t_tmr;
        wr(ADDR_TMR_SEL, 32'd15);
        wr(ADDR_TMR_HRS, 32'h0000270F);
        wr(ADDR_TMR_SUB, 32'h003B3B63);
        wr(ADDR_TMR_CMD, 32'h10);
        rd(ADDR_TMR_HRS);
        chk(q, 32'h0000270F);
        rd(ADDR_TMR_SUB);
        chk(q, 32'h003B3B63);
        wr(ADDR_TMR_CMD, 32'h03);
        rd(ADDR_TMR_STAT);
        chk(q, 32'h1);
        wr(ADDR_TMR_CMD, 32'h0C);
        rd(ADDR_TMR_STAT);
        chk(q, 32'h3);
        rd(ADDR_TMR_HRS);
        chk(q, 32'h0000270F);
        wr(ADDR_TMR_CMD, 32'h01);
        rd(ADDR_TMR_STAT);
        chk(q, 32'h2);
        wr(ADDR_TMR_ACC, 32'h0303);
        wr(ADDR_TMR_SEL, 32'd3);
        rd(ADDR_TMR_STAT);
        chk(q, 32'h1);
        wr(ADDR_TMR_SEL, 32'd0);
        wr(ADDR_TMR_CMD, 32'h20);
        rd(ADDR_TMR_STAT);
        chk(q, 32'h0);
        $display("test timers done");
    endtask
    task automatic t_unmap;
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24);
        chk(q, 32'h0);
        $display("test unmapped done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pin();
        t_lock();
        t_tout();
        t_tmr();
        t_unmap();
        close_out();
    end
    initial begin
        #(100 * 20000);
        num_errors++;
        close_out();
    end
endmodule // pin_timer_top_tb
bind pin_timer_top pin_timer_checker u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_busy(i_busy), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire
